// *** field_delay_pkg.sv ***
// shared constants of the field delay fifo
package field_delay_pkg;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned ADDR_W = 19;
    localparam int unsigned ARRAY_DEPTH = 262224;
    localparam logic [ADDR_W-1:0] LAST_ADDR = 19'h4004F;
    localparam int unsigned SRAM_WORDS = 80;
    localparam int unsigned BLOCK_WORDS = 64;
    localparam int unsigned PIN_W = 15;
    // clock and refresh timing
    localparam int unsigned CLK_PERIOD_PS = 5000;
    localparam int unsigned REFRESH_NS = 7800;
    localparam int unsigned REFRESH_CYCLES = REFRESH_NS * 1000 / CLK_PERIOD_PS;
    localparam int unsigned REF_CNT_W = 11;
    localparam int unsigned REF_ROW_W = 12;
    // apb register map
    localparam int unsigned PADDR_W = 12;
    localparam logic [PADDR_W-1:0] OFF_CTRL = 12'h000;
    localparam logic [PADDR_W-1:0] OFF_WPTR = 12'h004;
    localparam logic [PADDR_W-1:0] OFF_RPTR = 12'h008;
    localparam logic [PADDR_W-1:0] OFF_STATUS = 12'h00C;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    localparam int unsigned CTRL_WHOLD_BIT = 0;
    localparam int unsigned CTRL_RHOLD_BIT = 1;
endpackage : field_delay_pkg

// *** store_port_if.sv ***
// port bundle between pointer logic and storage array
`timescale 1ns/1ps
interface store_port_if #(
    parameter int unsigned AW = 19,
    parameter int unsigned DW = 8
);
    logic we;
    logic [AW-1:0] waddr;
    logic [DW-1:0] wdata;
    logic re;
    logic [AW-1:0] raddr;
    logic [DW-1:0] rdata;
    modport ctl (output we, waddr, wdata, re, raddr, input rdata);
    modport store (input we, waddr, wdata, re, raddr, output rdata);
endinterface : store_port_if

// *** pin_sync.sv ***
// two-stage synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
module pin_sync #(
    parameter int unsigned W = 15
) (
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic i_clk_en,
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    // first stage feeds only the second; idle level is high
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            meta_ff <= '1;
            sync_ff <= '1;
        end else if (i_clk_en) begin
            meta_ff <= i_async;
            sync_ff <= meta_ff;
        end
    end

    assign o_sync = sync_ff;
endmodule : pin_sync

// *** field_store.sv ***
// byte-wide storage array with registered read data
`timescale 1ns/1ps
module field_store #(
    parameter int unsigned AW = 19,
    parameter int unsigned DW = 8,
    parameter int unsigned DEPTH = 262224
) (
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic i_clk_en,
    store_port_if.store port
);
    logic [DW-1:0] mem [DEPTH];
    logic [DW-1:0] rdata_ff;

    // read-first: equal addresses return the byte stored a field ago
    always_ff @(posedge i_clk_sys) begin
        if (i_clk_en && port.we) begin
            mem[port.waddr] <= port.wdata;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            rdata_ff <= '0;
        end else if (i_clk_en && port.re) begin
            rdata_ff <= mem[port.raddr];
        end
    end

    assign port.rdata = rdata_ff;
endmodule : field_store

// *** field_delay_fifo.sv ***
// field delay fifo: pin sampling, address pointers, apb registers
`timescale 1ns/1ps
module field_delay_fifo
    import field_delay_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic i_clk_en,
    // write port pins
    input wire logic i_write_clock,
    input wire logic i_write_gate_n,
    input wire logic i_write_addr_reset_n,
    input wire logic [DATA_W-1:0] i_write_data_in,
    // read port pins
    input wire logic i_read_clock,
    input wire logic i_read_gate_n,
    input wire logic i_output_gate_n,
    input wire logic i_read_addr_reset_n,
    output logic [DATA_W-1:0] o_read_data_out,
    output logic o_read_data_oe,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [PADDR_W-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr
);

    typedef struct packed {
        logic [ADDR_W-1:0] wptr;
        logic [ADDR_W-1:0] rptr;
        logic write_addr_reset_n_pend;
        logic read_addr_reset_n_pend;
        logic wck_prev;
        logic rck_prev;
        logic rd_pend;
        logic oe;
        logic [DATA_W-1:0] dout;
        logic [1:0] ctrl;
        logic [31:0] prdata;
        logic pslverr;
        logic [REF_CNT_W-1:0] ref_cnt;
        logic [REF_ROW_W-1:0] ref_row;
    } fifo_state_s;

    fifo_state_s state_ff;
    fifo_state_s nxt_state;

    logic [PIN_W-1:0] pins_sync;
    logic s_wck;
    logic s_wgate_n;
    logic s_write_addr_reset_n_n;
    logic [DATA_W-1:0] s_wdata;
    logic s_rck;
    logic s_rgate_n;
    logic s_ogate_n;
    logic s_read_addr_reset_n_n;
    logic w_edge;
    logic r_edge;
    logic [ADDR_W-1:0] w_addr;
    logic [ADDR_W-1:0] r_addr;
    logic apb_setup;
    logic apb_wr;

    store_port_if #(.AW(ADDR_W), .DW(DATA_W)) mif ();

    // successor address; wraps at the last word of the array
    function automatic logic [ADDR_W-1:0] next_addr(
        input logic [ADDR_W-1:0] a
    );
        logic [ADDR_W-1:0] n;
        n = (a == LAST_ADDR) ? '0 : ADDR_W'(a + 1'b1);
        return n;
    endfunction : next_addr

    // true for word offsets inside the register map
    function automatic logic is_mapped(
        input logic [PADDR_W-1:0] a
    );
        logic hit;
        hit = (a == OFF_CTRL) || (a == OFF_WPTR)
            || (a == OFF_RPTR) || (a == OFF_STATUS);
        return hit;
    endfunction : is_mapped

    // every pin, clocks included, crosses in through two flops
    pin_sync #(.W(PIN_W)) u_pin_sync (
        .i_clk_sys(i_clk_sys),
        .i_reset_n(i_reset_n),
        .i_clk_en(i_clk_en),
        .i_async({i_write_clock, i_write_gate_n,
            i_write_addr_reset_n, i_write_data_in,
            i_read_clock, i_read_gate_n,
            i_output_gate_n, i_read_addr_reset_n}),
        .o_sync(pins_sync)
    );

    assign {s_wck, s_wgate_n, s_write_addr_reset_n_n, s_wdata,
        s_rck, s_rgate_n, s_ogate_n, s_read_addr_reset_n_n} = pins_sync;

    // whole array is directly addressed: no staging of blocks
    field_store #(
        .AW(ADDR_W),
        .DW(DATA_W),
        .DEPTH(ARRAY_DEPTH)
    ) u_store (
        .i_clk_sys(i_clk_sys),
        .i_reset_n(i_reset_n),
        .i_clk_en(i_clk_en),
        .port(mif.ctl)
    );

    // port clock rises seen in the system domain
    assign w_edge = s_wck && !state_ff.wck_prev
        && !state_ff.ctrl[CTRL_WHOLD_BIT];
    assign r_edge = s_rck && !state_ff.rck_prev
        && !state_ff.ctrl[CTRL_RHOLD_BIT];

    assign apb_setup = i_psel && !i_penable;
    assign apb_wr = i_psel && i_penable && i_pwrite;

    // next-state logic for both ports, refresh and registers
    always_comb begin
        nxt_state = state_ff;
        nxt_state.wck_prev = s_wck;
        nxt_state.rck_prev = s_rck;
        w_addr = state_ff.wptr;
        r_addr = state_ff.rptr;
        mif.we = 1'b0;
        mif.waddr = w_addr;
        mif.wdata = s_wdata;
        mif.re = 1'b0;
        mif.raddr = r_addr;

        // write port: reset sampled on its own clock edge
        if (w_edge) begin
            if (!s_wgate_n) begin
                if (!s_write_addr_reset_n_n || state_ff.write_addr_reset_n_pend) begin
                    w_addr = '0;
                end
                mif.we = 1'b1;
                mif.waddr = w_addr;
                nxt_state.wptr = next_addr(w_addr);
                nxt_state.write_addr_reset_n_pend = 1'b0;
            end else if (!s_write_addr_reset_n_n) begin
                nxt_state.write_addr_reset_n_pend = 1'b1;
            end
        end

        // read data lands one cycle after the array access
        if (state_ff.rd_pend) begin
            nxt_state.dout = mif.rdata;
            nxt_state.rd_pend = 1'b0;
        end

        // read port: output gate never stalls the pointer
        if (r_edge) begin
            nxt_state.oe = !s_ogate_n;
            if (!s_rgate_n) begin
                if (!s_read_addr_reset_n_n || state_ff.read_addr_reset_n_pend) begin
                    r_addr = '0;
                end
                mif.re = 1'b1;
                mif.raddr = r_addr;
                nxt_state.rptr = next_addr(r_addr);
                nxt_state.read_addr_reset_n_pend = 1'b0;
                nxt_state.rd_pend = 1'b1;
            end else if (!s_read_addr_reset_n_n) begin
                nxt_state.read_addr_reset_n_pend = 1'b1;
            end
        end

        // refresh timer walks the rows; no user action needed
        if (state_ff.ref_cnt == REF_CNT_W'(REFRESH_CYCLES - 1)) begin
            nxt_state.ref_cnt = '0;
            nxt_state.ref_row = REF_ROW_W'(state_ff.ref_row + 1'b1);
        end else begin
            nxt_state.ref_cnt = REF_CNT_W'(state_ff.ref_cnt + 1'b1);
        end

        // read data is latched in setup so it comes from a flop
        if (apb_setup) begin
            nxt_state.pslverr = !is_mapped(i_paddr);
            case (i_paddr)
                OFF_CTRL: begin
                    nxt_state.prdata = {30'h0, state_ff.ctrl};
                end
                OFF_WPTR: begin
                    nxt_state.prdata = {13'h0, state_ff.wptr};
                end
                OFF_RPTR: begin
                    nxt_state.prdata = {13'h0, state_ff.rptr};
                end
                OFF_STATUS: begin
                    // no fill level exists: spacing is the user's job
                    nxt_state.prdata = {17'h0, state_ff.ref_row,
                        state_ff.oe, state_ff.read_addr_reset_n_pend,
                        state_ff.write_addr_reset_n_pend};
                end
                default: begin
                    nxt_state.prdata = 32'h0;
                end
            endcase
        end

        // only the control word is writable
        if (apb_wr && i_paddr == OFF_CTRL) begin
            nxt_state.ctrl = i_pwdata[1:0];
        end
    end

    // single state register; clock enable freezes everything
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            state_ff <= '0;
            state_ff.wck_prev <= 1'b1;
            state_ff.rck_prev <= 1'b1;
            state_ff.ctrl <= CTRL_RESET;
        end else if (i_clk_en) begin
            state_ff <= nxt_state;
        end
    end

    // outputs straight from flops; zero-wait apb answer
    assign o_read_data_out = state_ff.dout;
    assign o_read_data_oe = state_ff.oe;
    assign o_prdata = state_ff.prdata;
    assign o_pslverr = state_ff.pslverr;
    assign o_pready = 1'b1;

    // checks below assume the enable high across each window
    default clocking dc @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_reset_n || !i_clk_en);

    property p_write_advance;
        w_edge && !s_wgate_n && s_write_addr_reset_n_n && !state_ff.write_addr_reset_n_pend
            |=> state_ff.wptr == next_addr($past(state_ff.wptr));
    endproperty
    a_write_advance: assert property (p_write_advance)
        else $error("write pointer did not advance");

    property p_write_hold;
        w_edge && s_wgate_n |=> $stable(state_ff.wptr);
    endproperty
    a_write_hold: assert property (p_write_hold)
        else $error("write pointer moved while gated");

    property p_read_data;
        r_edge && !s_rgate_n |=> ##1
            state_ff.dout == $past(mif.rdata);
    endproperty
    a_read_data: assert property (p_read_data)
        else $error("read byte not presented two cycles on");

    property p_read_hold;
        r_edge && s_rgate_n |=> $stable(state_ff.rptr);
    endproperty
    a_read_hold: assert property (p_read_hold)
        else $error("read pointer moved while gated");

    property p_output_gate;
        r_edge |=> o_read_data_oe == !$past(s_ogate_n);
    endproperty
    a_output_gate: assert property (p_output_gate)
        else $error("output enable does not follow the gate");

    property p_oe_indep;
        r_edge && !s_rgate_n && s_ogate_n && s_read_addr_reset_n_n
            && !state_ff.read_addr_reset_n_pend
            |=> state_ff.rptr == next_addr($past(state_ff.rptr));
    endproperty
    a_oe_indep: assert property (p_oe_indep)
        else $error("read pointer stalled by output gate");

    property p_reset_defer;
        w_edge && s_wgate_n && !s_write_addr_reset_n_n
            |=> state_ff.write_addr_reset_n_pend && $stable(state_ff.wptr);
    endproperty
    a_reset_defer: assert property (p_reset_defer)
        else $error("gated write reset not deferred");

    property p_reset_zero;
        w_edge && !s_wgate_n && !s_write_addr_reset_n_n
            |-> mif.we && mif.waddr == '0
            ##1 state_ff.wptr == 19'h00001;
    endproperty
    a_reset_zero: assert property (p_reset_zero)
        else $error("reset cycle not written at address 0");

    property p_write_wrap;
        w_edge && !s_wgate_n && s_write_addr_reset_n_n && !state_ff.write_addr_reset_n_pend
            && state_ff.wptr == LAST_ADDR |=> state_ff.wptr == '0;
    endproperty
    a_write_wrap: assert property (p_write_wrap)
        else $error("write pointer did not wrap");

    property p_refresh;
        state_ff.ref_cnt == REF_CNT_W'(REFRESH_CYCLES - 1)
            |=> state_ff.ref_row == REF_ROW_W'($past(state_ff.ref_row) + 1'b1)
            && state_ff.ref_cnt == '0;
    endproperty
    a_refresh: assert property (p_refresh)
        else $error("refresh row did not step");

    property p_c_write_reset;
        w_edge && !s_wgate_n && !s_write_addr_reset_n_n;
    endproperty
    c_write_reset: cover property (p_c_write_reset);

    property p_c_read_deferred;
        state_ff.read_addr_reset_n_pend ##[1:40] r_edge && !s_rgate_n;
    endproperty
    c_read_deferred: cover property (p_c_read_deferred);

    property p_c_hiz_read;
        r_edge && !s_rgate_n && s_ogate_n;
    endproperty
    c_hiz_read: cover property (p_c_hiz_read);

endmodule : field_delay_fifo

// *** video_source.sv ***
// video-side partner that drives the write and read pins of the fifo
`timescale 1ns/1ps
module video_source (
    input wire logic i_clk_sys,
    output logic o_write_clock,
    output logic o_write_gate_n,
    output logic o_write_addr_reset_n,
    output logic [7:0] o_write_data_in,
    output logic o_read_clock,
    output logic o_read_gate_n,
    output logic o_output_gate_n,
    output logic o_read_addr_reset_n
);
    int wcnt = 100;
    int rcnt = 100;
    // pins idle with clocks low so the first rise after reset is seen
    initial begin
        o_write_clock = 1'b0;
        o_write_gate_n = 1'b1;
        o_write_addr_reset_n = 1'b1;
        o_write_data_in = 8'h00;
        o_read_clock = 1'b0;
        o_read_gate_n = 1'b1;
        o_output_gate_n = 1'b1;
        o_read_addr_reset_n = 1'b1;
    end
    // one pin cycle on both ports: 5 edges low, 6 edges high
    task automatic cycle(input logic wg, input logic wr, input logic [7:0] wd,
                         input logic rg, input logic og, input logic rr);
        logic wr_ok;
        logic rr_ok;
        wr_ok = wr | (wcnt <= 82);
        rr_ok = rr | (rcnt <= 82);
        @(posedge i_clk_sys);
        o_write_gate_n <= wg;
        o_write_addr_reset_n <= wr_ok;
        o_write_data_in <= wd;
        o_read_gate_n <= rg & rr_ok;
        o_output_gate_n <= og;
        o_read_addr_reset_n <= rr_ok;
        repeat (4) @(posedge i_clk_sys);
        o_write_clock <= 1'b1;
        o_read_clock <= 1'b1;
        repeat (6) @(posedge i_clk_sys);
        o_write_clock <= 1'b0;
        o_read_clock <= 1'b0;
        // byte is no longer held once the cycle is over
        o_write_data_in <= ~wd;
        wcnt = (wr_ok ? wcnt : 0) + (wg ? 0 : 1);
        rcnt = (rr_ok ? rcnt : 0) + ((rg & rr_ok) ? 0 : 1);
    endtask : cycle
endmodule : video_source

// *** field_delay_fifo_bench.sv ***
// self-checking bench of the field delay fifo with a video-side partner
`timescale 1ns/1ps
module field_delay_fifo_bench
    import field_delay_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [PADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0;
    wire [31:0] prdata;
    wire pready;
    wire pslverr;
    wire write_clock, wg_n, write_addr_reset_n_n, read_clock, rg_n, og_n, read_addr_reset_n_n, oe;
    wire [DATA_W-1:0] wdata;
    wire [DATA_W-1:0] rdata;
    // resolved pin level seen by the video side
    wire [DATA_W-1:0] dbus = oe ? rdata : 8'hZZ;
    int fails = 0;
    int num_checks = 0;
    logic [DATA_W-1:0] mem [ARRAY_DEPTH];
    bit written [ARRAY_DEPTH];
    int wp = 0;
    int rp = 0;
    logic wpend = 1'b0;
    logic rpend = 1'b0;
    logic [DATA_W-1:0] last_rd = 8'h00;
    logic last_ok = 1'b0;

    always #2.5 clk = ~clk;

    video_source host (.i_clk_sys(clk), .o_write_clock(write_clock), .o_write_gate_n(wg_n),
        .o_write_addr_reset_n(write_addr_reset_n_n), .o_write_data_in(wdata), .o_read_clock(read_clock),
        .o_read_gate_n(rg_n), .o_output_gate_n(og_n), .o_read_addr_reset_n(read_addr_reset_n_n));

    field_delay_fifo uut (.i_clk_sys(clk), .i_reset_n(rst_n), .i_clk_en(ce),
        .i_write_clock(write_clock), .i_write_gate_n(wg_n), .i_write_addr_reset_n(write_addr_reset_n_n),
        .i_write_data_in(wdata), .i_read_clock(read_clock), .i_read_gate_n(rg_n),
        .i_output_gate_n(og_n), .i_read_addr_reset_n(read_addr_reset_n_n), .o_read_data_out(rdata),
        .o_read_data_oe(oe), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr));

    function automatic int bump(input int p);
        return (p + 1) % int'(ARRAY_DEPTH);
    endfunction : bump

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : report_and_stop

    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [PADDR_W-1:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // one pin cycle on both ports; the model reads before it writes
    task automatic step(input logic wg, input logic wr, input logic rg, input logic og,
                        input logic rr);
        logic [DATA_W-1:0] wd;
        wd = 8'($urandom);
        host.cycle(wg, wr, wd, rg, og, rr);
        // model follows the pins as the partner really drove them
        if (!read_addr_reset_n_n) rpend = 1'b1;
        if (!rg_n) begin
            if (rpend) rp = 0;
            rpend = 1'b0;
            last_ok = written[rp];
            if (last_ok) last_rd = mem[rp];
            rp = bump(rp);
        end
        if (!write_addr_reset_n_n) wpend = 1'b1;
        if (!wg_n) begin
            if (wpend) wp = 0;
            wpend = 1'b0;
            mem[wp] = wd;
            written[wp] = 1'b1;
            wp = bump(wp);
        end
        if (og) check({24'h0, dbus}, {24'h0, 8'hZZ});
        else if (last_ok) check({24'h0, dbus}, {24'h0, last_rd});
    endtask : step

    task automatic chk_ptrs();
        logic [31:0] v;
        logic e;
        apb(1'b0, OFF_WPTR, 32'h0, v, e);
        check(v, 32'(wp));
        apb(1'b0, OFF_RPTR, 32'h0, v, e);
        check(v, 32'(rp));
    endtask : chk_ptrs

    // cut a hang short well beyond the expected run length
    initial begin
        repeat (60000) @(posedge clk);
        fails++;
        report_and_stop();
    end

    initial begin
        logic [31:0] v;
        logic e;
        void'($urandom(32'h569C4887));
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        // control reads back, write pointer is read-only, unmapped place errs
        apb(1'b0, OFF_CTRL, 32'h0, v, e);
        check(v, 32'h0);
        apb(1'b1, OFF_CTRL, 32'h3, v, e);
        apb(1'b0, OFF_CTRL, 32'h0, v, e);
        check(v, 32'h3);
        apb(1'b1, OFF_CTRL, 32'h0, v, e);
        apb(1'b1, OFF_WPTR, 32'h1234, v, e);
        apb(1'b0, OFF_WPTR, 32'h0, v, e);
        check(v, 32'h0);
        apb(1'b0, 12'h010, 32'h0, v, e);
        check({31'h0, e}, 32'h1);
        // power-up: settle, both resets, more than 82 dummy cycles
        repeat (20001) @(posedge clk);
        step(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        repeat (83) step(1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
        // random gates on both ports after a common reset
        step(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        repeat (250) step(($urandom % 4) == 0, 1'b1, ($urandom % 4) == 0,
                          ($urandom % 4) == 0, 1'b1);
        chk_ptrs();
        // equal addresses read the previous field, reset under output gate
        step(1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
        repeat (100) step(1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
        // write reset while gated waits for the next enabled cycle
        step(1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
        step(1'b1, 1'b1, 1'b0, 1'b0, 1'b1);
        step(1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
        chk_ptrs();
        // write runs 200 ahead while reads hold, then new data is read
        repeat (200) step(1'b0, 1'b1, 1'b1, 1'b0, 1'b1);
        step(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
        repeat (100) step(1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
        chk_ptrs();
        // hold bits, then a low clock enable, must each ignore a pin cycle
        apb(1'b1, OFF_CTRL, 32'h3, v, e);
        host.cycle(1'b0, 1'b1, 8'hA5, 1'b0, 1'b0, 1'b1);
        chk_ptrs();
        apb(1'b1, OFF_CTRL, 32'h0, v, e);
        @(posedge clk);
        ce <= 1'b0;
        host.cycle(1'b0, 1'b1, 8'h5A, 1'b0, 1'b0, 1'b1);
        @(posedge clk);
        ce <= 1'b1;
        chk_ptrs();
        report_and_stop();
    end
endmodule : field_delay_fifo_bench
